// ### design/mtd_pkg.sv
package mtd_pkg;

  // Widths of the sample path, the register port and the trigger count.
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int CNT_W  = 7;

  // Register byte offsets on the plain register port.
  localparam logic [ADDR_W-1:0] OFS_VOLT_LEVEL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_VOLT_HYST  = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CURR_LEVEL = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CURR_HYST  = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_SLOPE      = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_SOURCE     = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNT      = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_SEQ_NAME   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_CMD        = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 6'h24;

  // Field positions.
  localparam int SLOPE_VOLT_LSB = 0;
  localparam int SLOPE_CURR_LSB = 2;
  localparam int SRC_BUS_BIT    = 0;
  localparam int SRC_CURR_BIT   = 1;
  localparam int SEQ1_LSB       = 0;
  localparam int SEQ2_LSB       = 2;
  localparam int CMD_INIT_BIT   = 0;
  localparam int CMD_ABORT_BIT  = 1;
  localparam int CMD_BUSTRG_BIT = 2;
  localparam int CMD_RESET_BIT  = 3;
  localparam int ST_INIT_BIT    = 0;
  localparam int ST_ERR_BIT     = 1;
  localparam int ST_REMAIN_LSB  = 8;

  // Reset values and legal ranges.
  localparam logic [DATA_W-1:0] LEVEL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] HYST_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  COUNT_MIN = 7'h01;
  localparam logic [CNT_W-1:0]  COUNT_MAX = 7'h64;
  localparam logic [CNT_W-1:0]  COUNT_RST = 7'h01;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 7'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 7'h01;

  typedef enum logic [1:0] {
    MTD_SLOPE_RISE   = 2'h0,
    MTD_SLOPE_FALL   = 2'h1,
    MTD_SLOPE_EITHER = 2'h2
  } mtd_slope_e;

  typedef enum logic [1:0] {
    MTD_NAME_TRANSIENT = 2'h1,
    MTD_NAME_MEASURE   = 2'h2
  } mtd_name_e;

  typedef enum logic [2:0] {
    MTD_SIDE_UNKNOWN = 3'b001,
    MTD_SIDE_BELOW   = 3'b010,
    MTD_SIDE_ABOVE   = 3'b100
  } mtd_side_e;

  typedef enum logic [1:0] {
    MTD_ARM_IDLE = 2'b01,
    MTD_ARM_WAIT = 2'b10
  } mtd_arm_e;

endpackage : mtd_pkg

// ### design/mtd_band_detect.sv
`timescale 1ns/1ps
module mtd_band_detect
  import mtd_pkg::*;
#(
  parameter int DW = DATA_W
) (
  // Clock, reset, enable.
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          ce,
  // Sample stream.
  input  wire logic          sample_valid,
  input  wire logic [DW-1:0] sample,
  // Settings.
  input  wire logic [DW-1:0] level,
  input  wire logic [DW-1:0] hyst,
  input  wire mtd_slope_e    slope,
  // Result.
  output logic               trig,
  output mtd_side_e          side
);

  // Half the hysteresis is added or subtracted; an odd setting loses its LSB.
  function automatic logic signed [DW+1:0] band_edge(input logic [DW-1:0] lvl,
                                                     input logic [DW-1:0] hy,
                                                     input logic          add);
    logic signed [DW+1:0] l;
    logic signed [DW+1:0] h;
    l = signed'({2'b00, lvl});
    h = signed'({3'b000, hy[DW-1:1]});
    return add ? l + h : l - h;
  endfunction : band_edge

  logic signed [DW+1:0] upper;
  logic signed [DW+1:0] lower;
  logic signed [DW+1:0] smp;
  logic                 is_above;
  logic                 is_below;
  logic                 rise_ok;
  logic                 fall_ok;
  mtd_side_e            next_side;

  assign upper    = band_edge(level, hyst, 1'b1);
  assign lower    = band_edge(level, hyst, 1'b0);
  assign smp      = signed'({2'b00, sample});
  assign is_above = smp > upper;
  assign is_below = smp < lower;
  assign rise_ok  = (slope == MTD_SLOPE_RISE) || (slope == MTD_SLOPE_EITHER);
  assign fall_ok  = (slope == MTD_SLOPE_FALL) || (slope == MTD_SLOPE_EITHER);

  // Inside the band the last side is kept, so slow crossings still count.
  always_comb begin
    next_side = side;
    if (is_above) begin
      next_side = MTD_SIDE_ABOVE;
    end else if (is_below) begin
      next_side = MTD_SIDE_BELOW;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      side <= MTD_SIDE_UNKNOWN;
    end else if (ce && sample_valid) begin
      side <= next_side;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      trig <= 1'b0;
    end else if (ce) begin
      case (side)
        MTD_SIDE_BELOW: trig <= sample_valid && is_above && rise_ok;
        MTD_SIDE_ABOVE: trig <= sample_valid && is_below && fall_ok;
        MTD_SIDE_UNKNOWN: trig <= 1'b0;
        default: trig <= 1'b0;
      endcase
    end
  end

  a_rise_fires: assert property (@(posedge clk) disable iff (srst)
    (ce && sample_valid && side == MTD_SIDE_BELOW && is_above && rise_ok) |=> trig)
    else $error("rising crossing did not fire");
  a_fire_cause: assert property (@(posedge clk) disable iff (srst)
    $rose(trig) |-> $past(sample_valid) && ($past(side) != MTD_SIDE_UNKNOWN))
    else $error("trigger without a qualified crossing");
  a_side_kept: assert property (@(posedge clk) disable iff (srst)
    (ce && sample_valid && !is_above && !is_below) |=> $stable(side))
    else $error("side changed inside the band");

endmodule : mtd_band_detect

// ### design/mtd_trigger_detector.sv
`timescale 1ns/1ps
// Function
// - Band edges are level plus and minus half the hysteresis setting.
// - Positive trigger only when rising from below lower edge past upper edge.
// - Negative trigger only when falling from above upper edge past lower edge.
// - Voltage hysteresis is programmable, resets to zero, reads back.
// - Current trigger level is programmable, resets to zero, reads back.
// - Voltage trigger level is separate, resets to zero, reads back.
// - Slope picks rising, falling or both crossing directions.
// - Current slope selection resets to rising and reads back.
// - Voltage slope selection is independent, resets to rising, reads back.
// - Internal source triggers as soon as the selected crossing occurs.
// - Source is bus or internal, internal after reset; host sends bus triggers.
// - Sequence one accepts only the transient name, two only the measure name.
// - Queries return the names aliased to both sequences.
// - Each accepted trigger while initiated starts a measure-and-store.
// - Trigger count 1 to 100, default 1; rearm until count exhausted.
module mtd_trigger_detector
  import mtd_pkg::*;
#(
  parameter int DW = DATA_W
) (
  // Clock, reset, enable.
  input  wire logic              SYS_CLK,
  input  wire logic              SRST,
  input  wire logic              CE,
  // Register port.
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [31:0]       RDATA,
  // Measured samples and bus trigger from the same clock domain.
  input  wire logic              SAMPLE_VALID,
  input  wire logic [DW-1:0]     VOLT_SAMPLE,
  input  wire logic [DW-1:0]     CURR_SAMPLE,
  input  wire logic              BUS_TRIGGER,
  // Trigger system outputs.
  output logic                   MEAS_TRIG,
  output logic                   INITIATED
);

  logic [DW-1:0]    volt_level;
  logic [DW-1:0]    volt_hyst;
  logic [DW-1:0]    curr_level;
  logic [DW-1:0]    curr_hyst;
  mtd_slope_e       volt_slope;
  mtd_slope_e       curr_slope;
  logic             src_bus;
  logic             src_curr;
  logic [CNT_W-1:0] trig_count;
  mtd_name_e        first_trigger_sequence;
  mtd_name_e        second_trigger_sequence;
  logic             prog_error;
  mtd_arm_e         arm;
  logic [CNT_W-1:0] remain;

  logic             wr_hit;
  logic             cmd_reset;
  logic             cmd_init;
  logic             cmd_abort;
  logic             bus_event;
  logic             volt_trig;
  logic             curr_trig;
  logic             int_event;
  logic             accept;
  logic             bad_write;
  logic [CNT_W-1:0] wr_count;
  logic [1:0]       wr_vslope;
  logic [1:0]       wr_cslope;
  logic [1:0]       wr_seq1;
  logic [1:0]       wr_seq2;
  logic [31:0]      next_rdata;
  mtd_side_e        volt_side;
  mtd_side_e        curr_side;

  assign wr_hit    = CE && WR;
  assign cmd_reset = wr_hit && (ADDR == OFS_CMD) && WDATA[CMD_RESET_BIT];
  assign cmd_init  = wr_hit && (ADDR == OFS_CMD) && WDATA[CMD_INIT_BIT];
  assign cmd_abort = wr_hit && (ADDR == OFS_CMD) && WDATA[CMD_ABORT_BIT];
  assign wr_count  = WDATA[CNT_W-1:0];
  assign wr_vslope = WDATA[SLOPE_VOLT_LSB +: 2];
  assign wr_cslope = WDATA[SLOPE_CURR_LSB +: 2];
  assign wr_seq1   = WDATA[SEQ1_LSB +: 2];
  assign wr_seq2   = WDATA[SEQ2_LSB +: 2];

  // The bus trigger arrives either on the pin or as a command bit.
  assign bus_event = BUS_TRIGGER || (wr_hit && (ADDR == OFS_CMD) && WDATA[CMD_BUSTRG_BIT]);
  assign int_event = src_curr ? curr_trig : volt_trig;
  assign accept    = CE && (arm == MTD_ARM_WAIT) && !cmd_reset && !cmd_abort
                     && (src_bus ? bus_event : int_event);

  // Values outside the legal set are refused and leave the old setting.
  always_comb begin
    bad_write = 1'b0;
    if (wr_hit && !cmd_reset) begin
      case (ADDR)
        OFS_SLOPE:    bad_write = (wr_vslope > MTD_SLOPE_EITHER) || (wr_cslope > MTD_SLOPE_EITHER);
        OFS_COUNT:    bad_write = (wr_count < COUNT_MIN) || (wr_count > COUNT_MAX);
        OFS_SEQ_NAME: bad_write = (wr_seq1 != MTD_NAME_TRANSIENT)
                                  || (wr_seq2 != MTD_NAME_MEASURE);
        default:      bad_write = 1'b0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST || (CE && cmd_reset)) begin
      volt_level <= LEVEL_RST;
      volt_hyst  <= HYST_RST;
      curr_level <= LEVEL_RST;
      curr_hyst  <= HYST_RST;
    end else if (wr_hit) begin
      case (ADDR)
        OFS_VOLT_LEVEL: volt_level <= WDATA[DW-1:0];
        OFS_VOLT_HYST:  volt_hyst  <= WDATA[DW-1:0];
        OFS_CURR_LEVEL: curr_level <= WDATA[DW-1:0];
        OFS_CURR_HYST:  curr_hyst  <= WDATA[DW-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST || (CE && cmd_reset)) begin
      volt_slope <= MTD_SLOPE_RISE;
      curr_slope <= MTD_SLOPE_RISE;
      src_bus    <= 1'b0;
      src_curr   <= 1'b0;
      trig_count <= COUNT_RST;
    end else if (wr_hit && !bad_write) begin
      case (ADDR)
        OFS_SLOPE: begin
          volt_slope <= mtd_slope_e'(wr_vslope);
          curr_slope <= mtd_slope_e'(wr_cslope);
        end
        OFS_SOURCE: begin
          src_bus  <= WDATA[SRC_BUS_BIT];
          src_curr <= WDATA[SRC_CURR_BIT];
        end
        OFS_COUNT: trig_count <= wr_count;
        default: begin
        end
      endcase
    end
  end

  // The aliases can only ever take their one legal name, so they never move.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      first_trigger_sequence  <= MTD_NAME_TRANSIENT;
      second_trigger_sequence <= MTD_NAME_MEASURE;
    end else if (wr_hit && (ADDR == OFS_SEQ_NAME) && !bad_write) begin
      first_trigger_sequence  <= mtd_name_e'(wr_seq1);
      second_trigger_sequence <= mtd_name_e'(wr_seq2);
    end
  end

  // Refused writes are sticky; a status read clears, a new refusal wins.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      prog_error <= 1'b0;
    end else if (CE && bad_write) begin
      prog_error <= 1'b1;
    end else if (CE && RD && (ADDR == OFS_STATUS)) begin
      prog_error <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      arm    <= MTD_ARM_IDLE;
      remain <= CNT_ZERO;
    end else if (CE) begin
      case (arm)
        MTD_ARM_IDLE: begin
          if (cmd_init && !cmd_reset && !cmd_abort) begin
            arm    <= MTD_ARM_WAIT;
            remain <= trig_count;
          end
        end
        MTD_ARM_WAIT: begin
          if (cmd_reset || cmd_abort) begin
            arm    <= MTD_ARM_IDLE;
            remain <= CNT_ZERO;
          end else if (accept) begin
            remain <= remain - CNT_ONE;
            if (remain == CNT_ONE) begin
              arm <= MTD_ARM_IDLE;
            end
          end
        end
        default: begin
          arm    <= MTD_ARM_IDLE;
          remain <= CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      MEAS_TRIG <= 1'b0;
      INITIATED <= 1'b0;
    end else if (CE) begin
      MEAS_TRIG <= accept;
      INITIATED <= (arm == MTD_ARM_WAIT);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (ADDR)
      OFS_VOLT_LEVEL: next_rdata[DW-1:0] = volt_level;
      OFS_VOLT_HYST:  next_rdata[DW-1:0] = volt_hyst;
      OFS_CURR_LEVEL: next_rdata[DW-1:0] = curr_level;
      OFS_CURR_HYST:  next_rdata[DW-1:0] = curr_hyst;
      OFS_SLOPE: begin
        next_rdata[SLOPE_VOLT_LSB +: 2] = volt_slope;
        next_rdata[SLOPE_CURR_LSB +: 2] = curr_slope;
      end
      OFS_SOURCE: begin
        next_rdata[SRC_BUS_BIT]  = src_bus;
        next_rdata[SRC_CURR_BIT] = src_curr;
      end
      OFS_COUNT: next_rdata[CNT_W-1:0] = trig_count;
      OFS_SEQ_NAME: begin
        next_rdata[SEQ1_LSB +: 2] = first_trigger_sequence;
        next_rdata[SEQ2_LSB +: 2] = second_trigger_sequence;
      end
      OFS_STATUS: begin
        next_rdata[ST_INIT_BIT]              = (arm == MTD_ARM_WAIT);
        next_rdata[ST_ERR_BIT]               = prog_error;
        next_rdata[ST_REMAIN_LSB +: CNT_W]   = remain;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stand for one enabled cycle after a read and are zero otherwise; CE low holds them.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      RDATA <= 32'h0000_0000;
    end else if (CE) begin
      RDATA <= RD ? next_rdata : 32'h0000_0000;
    end
  end

  mtd_band_detect #(.DW(DW)) u_volt_detect (
    .clk          (SYS_CLK),
    .srst         (SRST),
    .ce           (CE),
    .sample_valid (SAMPLE_VALID),
    .sample       (VOLT_SAMPLE),
    .level        (volt_level),
    .hyst         (volt_hyst),
    .slope        (volt_slope),
    .trig         (volt_trig),
    .side         (volt_side)
  );

  mtd_band_detect #(.DW(DW)) u_curr_detect (
    .clk          (SYS_CLK),
    .srst         (SRST),
    .ce           (CE),
    .sample_valid (SAMPLE_VALID),
    .sample       (CURR_SAMPLE),
    .level        (curr_level),
    .hyst         (curr_hyst),
    .slope        (curr_slope),
    .trig         (curr_trig),
    .side         (curr_side)
  );

  a_reset_defaults: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (CE && cmd_reset) |=> (volt_hyst == HYST_RST) && (volt_level == LEVEL_RST)
                          && (curr_level == LEVEL_RST) && !src_bus
                          && (trig_count == COUNT_RST))
    else $error("reset command did not restore defaults");
  a_slope_default: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (CE && cmd_reset) |=> (curr_slope == MTD_SLOPE_RISE) && (volt_slope == MTD_SLOPE_RISE))
    else $error("slopes not rising after reset command");
  a_names_fixed: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (first_trigger_sequence == MTD_NAME_TRANSIENT)
    && (second_trigger_sequence == MTD_NAME_MEASURE))
    else $error("sequence alias took an illegal name");
  a_name_readback: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (CE && RD && ADDR == OFS_SEQ_NAME) |=>
      (RDATA[SEQ1_LSB +: 2] == MTD_NAME_TRANSIENT) && (RDATA[SEQ2_LSB +: 2] == MTD_NAME_MEASURE))
    else $error("alias query returned wrong names");
  a_meas_follows: assert property (@(posedge SYS_CLK) disable iff (SRST)
    accept |=> MEAS_TRIG ##1 (!MEAS_TRIG || !$past(CE) || $past(accept)))
    else $error("measurement pulse does not follow acceptance");
  a_internal_fires: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (CE && arm == MTD_ARM_WAIT && !src_bus && !src_curr && volt_trig
     && !WR) |=> MEAS_TRIG)
    else $error("internal crossing did not trigger");
  a_bus_ignored: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (CE && !src_bus && !int_event) |=> !MEAS_TRIG)
    else $error("bus trigger taken in internal mode");
  a_count_done: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (accept && remain == CNT_ONE) |=> (arm == MTD_ARM_IDLE) ##1 (!INITIATED || !$past(CE)))
    else $error("trigger system stayed armed after last count");
  a_count_range: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (trig_count >= COUNT_MIN) && (trig_count <= COUNT_MAX))
    else $error("trigger count outside its range");

  c_bus_trigger: cover property (@(posedge SYS_CLK) disable iff (SRST) accept && src_bus);
  c_curr_trigger: cover property (@(posedge SYS_CLK) disable iff (SRST)
    accept && !src_bus && src_curr);
  c_multi_count: cover property (@(posedge SYS_CLK) disable iff (SRST)
    accept && remain > CNT_ONE);
  c_refused: cover property (@(posedge SYS_CLK) disable iff (SRST) CE && bad_write);
  c_both_above: cover property (@(posedge SYS_CLK) disable iff (SRST)
    accept && (volt_side == MTD_SIDE_ABOVE) && (curr_side == MTD_SIDE_ABOVE));

endmodule : mtd_trigger_detector

// ### sim/mtd_host_model.sv
`timescale 1ns/1ps
module mtd_host_model
  import mtd_pkg::*;
(
  // Clock.
  input  wire logic              SYS_CLK,
  // Register port towards the device.
  output logic      [ADDR_W-1:0] ADDR,
  output logic      [31:0]       WDATA,
  output logic                   WR,
  output logic                   RD,
  input  wire logic [31:0]       RDATA,
  // Bus trigger towards the device.
  output logic                   BUS_TRIGGER
);
  initial begin
    ADDR        = '0;
    WDATA       = '0;
    WR          = 1'b0;
    RD          = 1'b0;
    BUS_TRIGGER = 1'b0;
  end

  // Released address and data show the inverse so stale values are never mistaken for live ones.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge SYS_CLK);
    WR    <= 1'b0;
    ADDR  <= ~a;
    WDATA <= ~d;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge SYS_CLK);
    RD   <= 1'b0;
    ADDR <= ~a;
    #1;
    d = RDATA;
  endtask : rd

  task automatic bus_trig();
    @(posedge SYS_CLK);
    BUS_TRIGGER <= 1'b1;
    @(posedge SYS_CLK);
    BUS_TRIGGER <= 1'b0;
  endtask : bus_trig
endmodule : mtd_host_model

// ### sim/mtd_trigger_detector_bench.sv
`timescale 1ns/1ps
module mtd_trigger_detector_bench;
  import mtd_pkg::*;

  logic              clk;
  logic              srst;
  logic              ce;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata;
  logic              wr;
  logic              rd;
  logic [31:0]       rdata;
  logic              sv;
  logic [15:0]       vs;
  logic [15:0]       cs;
  logic              btrg;
  logic              meas_trig;
  logic              initiated;
  logic [31:0]       d;
  int                n_errors;
  int                num_checks;
  logic [ADDR_W-1:0] ofs [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C};
  logic [31:0]       rv  [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h9};

  mtd_trigger_detector mtd_trigger_detector_inst (
    .SYS_CLK      (clk),
    .SRST         (srst),
    .CE           (ce),
    .ADDR         (addr),
    .WDATA        (wdata),
    .WR           (wr),
    .RD           (rd),
    .RDATA        (rdata),
    .SAMPLE_VALID (sv),
    .VOLT_SAMPLE  (vs),
    .CURR_SAMPLE  (cs),
    .BUS_TRIGGER  (btrg),
    .MEAS_TRIG    (meas_trig),
    .INITIATED    (initiated)
  );

  mtd_host_model mtd_host_model_inst (
    .SYS_CLK     (clk),
    .ADDR        (addr),
    .WDATA       (wdata),
    .WR          (wr),
    .RD          (rd),
    .RDATA       (rdata),
    .BUS_TRIGGER (btrg)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Counts trigger pulses from just after the current edge through the next four, so a bus
  // pulse launched by the edge that ended the last call is seen as well as an internal one.
  task automatic watch(input logic [31:0] exp);
    logic [31:0] n;
    n = 32'h0;
    #1;
    if (meas_trig === 1'b1) n++;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (meas_trig === 1'b1) n++;
    end
    chk(n, exp);
  endtask : watch

  task automatic smp(input logic [15:0] v, input logic [15:0] c, input logic [31:0] exp);
    @(posedge clk);
    sv <= 1'b1;
    vs <= v;
    cs <= c;
    @(posedge clk);
    sv <= 1'b0;
    watch(exp);
  endtask : smp

  task automatic arm();
    mtd_host_model_inst.wr(OFS_CMD, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, initiated}, 32'h1);
  endtask : arm

  initial begin
    #100us;
    n_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    n_errors   = 0;
    num_checks = 0;
    srst       = 1'b1;
    ce         = 1'b1;
    sv         = 1'b0;
    vs         = 16'h0000;
    cs         = 16'h0000;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      mtd_host_model_inst.rd(ofs[i], d);
      chk(d, rv[i]);
    end
    mtd_host_model_inst.wr(OFS_VOLT_LEVEL, 32'h1000);
    mtd_host_model_inst.wr(OFS_VOLT_HYST, 32'h0200);
    mtd_host_model_inst.rd(OFS_VOLT_HYST, d);
    chk(d, 32'h0200);
    mtd_host_model_inst.rd(OFS_VOLT_LEVEL, d);
    chk(d, 32'h1000);
    // A write made while the clock enable is low must leave the level untouched.
    ce <= 1'b0;
    mtd_host_model_inst.wr(OFS_VOLT_LEVEL, 32'h2000);
    ce <= 1'b1;
    mtd_host_model_inst.rd(OFS_VOLT_LEVEL, d);
    chk(d, 32'h1000);
    mtd_host_model_inst.rd(6'h3C, d);
    chk(d, 32'h0);
    // Swapped names must be refused and flagged; the flag clears on read.
    mtd_host_model_inst.wr(OFS_SEQ_NAME, 32'h6);
    mtd_host_model_inst.rd(OFS_SEQ_NAME, d);
    chk(d, 32'h9);
    mtd_host_model_inst.rd(OFS_STATUS, d);
    chk({31'h0, d[ST_ERR_BIT]}, 32'h1);
    mtd_host_model_inst.rd(OFS_STATUS, d);
    chk({31'h0, d[ST_ERR_BIT]}, 32'h0);
    mtd_host_model_inst.wr(OFS_SLOPE, 32'h3);
    mtd_host_model_inst.rd(OFS_SLOPE, d);
    chk(d, 32'h0);
    // Band is 0x0F00 to 0x1100; touching a limit is not passing it.
    mtd_host_model_inst.wr(OFS_COUNT, 32'h2);
    arm();
    smp(16'h0E00, 16'h0, 32'h0);
    smp(16'h1100, 16'h0, 32'h0);
    smp(16'h1101, 16'h0, 32'h1);
    smp(16'h0EFF, 16'h0, 32'h0);
    smp(16'h1101, 16'h0, 32'h1);
    chk({31'h0, initiated}, 32'h0);
    smp(16'h0EFF, 16'h0, 32'h0);
    smp(16'h1101, 16'h0, 32'h0);
    mtd_host_model_inst.wr(OFS_SLOPE, 32'h1);
    mtd_host_model_inst.wr(OFS_COUNT, 32'h1);
    arm();
    smp(16'h1200, 16'h0, 32'h0);
    smp(16'h0F00, 16'h0, 32'h0);
    smp(16'h0EFF, 16'h0, 32'h1);
    mtd_host_model_inst.wr(OFS_SLOPE, 32'h2);
    mtd_host_model_inst.wr(OFS_COUNT, 32'h2);
    arm();
    smp(16'h1101, 16'h0, 32'h1);
    smp(16'h0EFF, 16'h0, 32'h1);
    // Current signal with rising slope while the voltage slope stays on either edge.
    mtd_host_model_inst.wr(OFS_CURR_LEVEL, 32'h0800);
    mtd_host_model_inst.rd(OFS_CURR_LEVEL, d);
    chk(d, 32'h0800);
    mtd_host_model_inst.wr(OFS_SOURCE, 32'h2);
    mtd_host_model_inst.wr(OFS_COUNT, 32'h1);
    mtd_host_model_inst.rd(OFS_SLOPE, d);
    chk(d, 32'h2);
    arm();
    smp(16'h1101, 16'h07FF, 32'h0);
    smp(16'h1101, 16'h0801, 32'h1);
    // Bus source ignores crossings and answers the host's trigger.
    mtd_host_model_inst.wr(OFS_SOURCE, 32'h1);
    arm();
    smp(16'h0EFF, 16'h0, 32'h0);
    mtd_host_model_inst.bus_trig();
    watch(32'h1);
    mtd_host_model_inst.bus_trig();
    watch(32'h0);
    // The command bit triggers like the pin; an abort drops the remaining count.
    arm();
    mtd_host_model_inst.wr(OFS_CMD, 32'h4);
    watch(32'h1);
    mtd_host_model_inst.wr(OFS_COUNT, 32'h2);
    arm();
    mtd_host_model_inst.rd(OFS_STATUS, d);
    chk({25'h0, d[ST_REMAIN_LSB +: CNT_W]}, 32'h2);
    chk({31'h0, d[ST_ERR_BIT]}, 32'h1);
    mtd_host_model_inst.wr(OFS_CMD, 32'h2);
    mtd_host_model_inst.bus_trig();
    watch(32'h0);
    chk({31'h0, initiated}, 32'h0);
    mtd_host_model_inst.wr(OFS_CMD, 32'h8);
    mtd_host_model_inst.rd(OFS_SOURCE, d);
    chk(d, 32'h0);
    mtd_host_model_inst.rd(OFS_VOLT_HYST, d);
    chk(d, 32'h0);
    mtd_host_model_inst.rd(OFS_SLOPE, d);
    chk(d, 32'h0);
    mtd_host_model_inst.rd(OFS_SEQ_NAME, d);
    chk(d, 32'h9);
    end_of_test();
  end
endmodule : mtd_trigger_detector_bench
